// ===== rqts_map.svh
`ifndef RQTS_MAP_SVH
`define RQTS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RQTS_CTRL_OFF      8'h00
`define RQTS_STATUS_OFF    8'h04
`define RQTS_SIDEBAND_OFF  8'h08
`define RQTS_NPCOUNT_OFF   8'h0c
`define RQTS_ERR_OFF       8'h10

// ----------------------------------------
// Control fields and reset
// ----------------------------------------
`define RQTS_CTRL_UTAG_BIT   0
`define RQTS_CTRL_ALIGN_BIT  1
`define RQTS_CTRL_ACCEPT_BIT 2
`define RQTS_CTRL_RST        3'h4

// ----------------------------------------
// Status fields
// ----------------------------------------
`define RQTS_STAT_LEVEL_LSB  0
`define RQTS_STAT_FULL_BIT   4
`define RQTS_STAT_INPKT_BIT  5
`define RQTS_STAT_TAG_LSB    8

// ----------------------------------------
// Sideband fields
// ----------------------------------------
`define RQTS_FBE_LSB         0
`define RQTS_LBE_LSB         4
`define RQTS_OFS_LSB         8
`define RQTS_OFS_MAX         3'h3

// ----------------------------------------
// Descriptor request type and posted codes
// ----------------------------------------
`define RQTS_TYPE_LSB        75
`define RQTS_TYPE_MWR        4'h1
`define RQTS_TYPE_MSG_LO     4'hc
`define RQTS_TYPE_MSG_HI     4'he

// ----------------------------------------
// Tag queue and bus
// ----------------------------------------
`define RQTS_FIFO_DEPTH      8
`define RQTS_HTRANS_NONSEQ   2'h2
`define RQTS_HSIZE_WORD      3'h2

`endif

// ===== rqts_pkg.sv
package rqts_pkg;

    typedef logic [5:0] rqts_tag_t;

    typedef struct packed {
        logic [2:0] offset;
        logic [3:0] final_dword_byte_enables;
        logic [3:0] first_dword_byte_enables;
    } rqts_sideband_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
    } rqts_aphase_t;

endpackage

// ===== rqts_tag_fifo.sv
`timescale 1ns/1ps
`include "rqts_map.svh"

module rqts_tag_fifo (
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // Fill side
    input  wire logic              push,
    input  wire rqts_pkg::rqts_tag_t din,
    output logic                   full,
    // Drain side
    input  wire logic              pop,
    output rqts_pkg::rqts_tag_t    dout,
    output logic                   empty,
    output logic [3:0]             level
);
    import rqts_pkg::*;

    rqts_tag_t  mem [`RQTS_FIFO_DEPTH];
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic [3:0] count;
    wire        do_push = push && !full;
    wire        do_pop  = pop && !empty;

    assign full  = (count == 4'(`RQTS_FIFO_DEPTH));
    assign empty = (count == 4'h0);
    assign level = count;
    assign dout  = mem[rd_ptr];

    // ----------------------------------------
    // Storage entries
    // ----------------------------------------
    for (genvar i = 0; i < `RQTS_FIFO_DEPTH; i++) begin : g_entry
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                mem[i] <= 6'h00;
            end else if (do_push && wr_ptr == 3'(i)) begin
                mem[i] <= din;
            end
        end
    end

    // ----------------------------------------
    // Pointers, first-in first-out
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            count  <= 4'h0;
        end else begin
            wr_ptr <= wr_ptr + 3'(do_push);
            rd_ptr <= rd_ptr + 3'(do_pop);
            count  <= count + 4'(do_push) - 4'(do_pop);
        end
    end

endmodule

// ===== rqts_core.sv
`timescale 1ns/1ps
`include "rqts_map.svh"

// Contract
// - With core tag management, each accepted non-posted request gets a 6-bit tag output.
// - The tag valid output pulses one cycle per tag, and the tag is meaningful only then.
// - Tags may come several cycles late, while further requests keep being accepted.
// - Tags are reported in the order the non-posted requests were accepted.
// - Byte enables and offset are sampled only in the first beat with valid and ready high.
// - A beat moves only when valid and ready are both high, and stalled beats are held.

module rqts_core (
    // Clock and reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // AHB-Lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic [31:0]                  hrdata,
    output logic                         hresp,
    // Request stream
    input  wire logic [127:0]            request_data_bus,
    input  wire logic [59:0]             request_sideband_bus,
    input  wire logic                    request_last,
    input  wire logic [3:0]              request_keep,
    input  wire logic                    request_valid,
    output logic [3:0]                   request_ready,
    // Tag report
    output rqts_pkg::rqts_tag_t          nonposted_tag_out,
    output logic                         nonposted_tag_valid,
    // Sampled packet sideband
    output rqts_pkg::rqts_sideband_t     packet_sideband,
    output logic                         packet_start
);
    import rqts_pkg::*;

    // ----------------------------------------
    // Control and state
    // ----------------------------------------
    logic [2:0]     ctrl;
    logic           in_pkt;
    logic           offset_err;
    logic [31:0]    np_count;
    rqts_tag_t      next_tag;
    rqts_tag_t      last_tag;
    rqts_aphase_t   aphase;
    rqts_sideband_t sideband_q;
    rqts_tag_t      tag_q;
    logic           tag_valid_q;
    logic           start_q;
    logic [31:0]    rdata_q;

    wire user_tag_mgmt_enable = ctrl[`RQTS_CTRL_UTAG_BIT];
    wire addr_aligned_mode    = ctrl[`RQTS_CTRL_ALIGN_BIT];
    wire accept_enable        = ctrl[`RQTS_CTRL_ACCEPT_BIT];

    // ----------------------------------------
    // Tag queue wires
    // ----------------------------------------
    wire        fifo_full;
    wire        fifo_empty;
    wire [3:0]  fifo_level;
    rqts_tag_t  fifo_dout;

    // ----------------------------------------
    // Stream handshake and first beat
    // ----------------------------------------
    wire ready_bit  = accept_enable && !fifo_full;
    wire beat       = request_valid && ready_bit;
    wire first_beat = beat && !in_pkt;

    assign request_ready = {4{ready_bit}};

    // ----------------------------------------
    // Request classification
    // ----------------------------------------
    wire [3:0] req_type = request_data_bus[`RQTS_TYPE_LSB +: 4];
    wire is_msg     = (req_type >= `RQTS_TYPE_MSG_LO) &&
                      (req_type <= `RQTS_TYPE_MSG_HI);
    wire is_posted  = (req_type == `RQTS_TYPE_MWR) || is_msg;
    wire np_accept  = first_beat && !is_posted;
    wire tag_alloc  = np_accept && !user_tag_mgmt_enable;

    // ----------------------------------------
    // Sideband field split
    // ----------------------------------------
    rqts_sideband_t sb_in;
    assign sb_in.first_dword_byte_enables =
        request_sideband_bus[`RQTS_FBE_LSB +: 4];
    assign sb_in.final_dword_byte_enables =
        request_sideband_bus[`RQTS_LBE_LSB +: 4];
    assign sb_in.offset =
        request_sideband_bus[`RQTS_OFS_LSB +: 3];

    wire ofs_bad_dword   = !addr_aligned_mode && (sb_in.offset != 3'h0);
    wire ofs_bad_aligned = addr_aligned_mode && (sb_in.offset > `RQTS_OFS_MAX);
    wire ofs_bad         = first_beat && (ofs_bad_dword || ofs_bad_aligned);

    // ----------------------------------------
    // Tag report, drained in queue order
    // ----------------------------------------
    wire tag_pop = !fifo_empty && !user_tag_mgmt_enable;

    rqts_tag_fifo u_tag_fifo (
        .hclk    (hclk),
        .hresetn (hresetn),
        .push    (tag_alloc),
        .din     (next_tag),
        .full    (fifo_full),
        .pop     (tag_pop),
        .dout    (fifo_dout),
        .empty   (fifo_empty),
        .level   (fifo_level)
    );

    assign nonposted_tag_out   = tag_q;
    assign nonposted_tag_valid = tag_valid_q;
    assign packet_sideband     = sideband_q;
    assign packet_start        = start_q;

    // ----------------------------------------
    // Packet tracking
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_pkt <= 1'b0;
        end else if (beat) begin
            in_pkt <= !request_last;
        end
    end

    // ----------------------------------------
    // Sideband capture on first beat only
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sideband_q <= '0;
            start_q    <= 1'b0;
        end else begin
            start_q <= first_beat;
            if (first_beat) begin
                sideband_q <= sb_in;
            end
        end
    end

    // ----------------------------------------
    // Tag allocation counter and non-posted request counter
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            next_tag <= 6'h00;
            np_count <= 32'h0000_0000;
        end else begin
            if (tag_alloc) begin
                next_tag <= next_tag + 6'h01;
            end
            if (np_accept) begin
                np_count <= np_count + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------
    // Tag output register
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tag_q       <= 6'h00;
            tag_valid_q <= 1'b0;
            last_tag    <= 6'h00;
        end else begin
            tag_valid_q <= tag_pop;
            if (tag_pop) begin
                tag_q    <= fifo_dout;
                last_tag <= fifo_dout;
            end
        end
    end

    // ----------------------------------------
    // AHB address phase decode
    // ----------------------------------------
    wire ahb_take = hsel && hready && (htrans == `RQTS_HTRANS_NONSEQ);
    wire size_ok  = (hsize == `RQTS_HSIZE_WORD);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aphase <= '0;
        end else if (hready) begin
            aphase.valid <= ahb_take && size_ok;
            aphase.write <= hwrite;
            aphase.addr  <= haddr[7:0];
        end
    end

    wire wr_data  = aphase.valid && aphase.write;
    wire wr_ctrl  = wr_data && (aphase.addr == `RQTS_CTRL_OFF);
    wire wr_err   = wr_data && (aphase.addr == `RQTS_ERR_OFF);

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `RQTS_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= hwdata[2:0];
        end
    end

    // ----------------------------------------
    // Offset error flag, set wins over clear
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            offset_err <= 1'b0;
        end else if (ofs_bad) begin
            offset_err <= 1'b1;
        end else if (wr_err && hwdata[0]) begin
            offset_err <= 1'b0;
        end
    end

    // ----------------------------------------
    // Read data selection
    // ----------------------------------------
    wire [31:0] stat_word = {18'h0, last_tag, 2'h0, in_pkt, fifo_full, fifo_level};
    wire [31:0] sb_word   = {21'h0, sideband_q};
    wire [31:0] ctrl_word = {29'h0, ctrl};
    wire [31:0] err_word  = {31'h0, offset_err};
    wire [7:0]  ra        = haddr[7:0];

    wire [31:0] next_rdata =
        (ra == `RQTS_CTRL_OFF)     ? ctrl_word :
        (ra == `RQTS_STATUS_OFF)   ? stat_word :
        (ra == `RQTS_SIDEBAND_OFF) ? sb_word   :
        (ra == `RQTS_NPCOUNT_OFF)  ? np_count  :
        (ra == `RQTS_ERR_OFF)      ? err_word  : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (ahb_take && !hwrite) begin
            rdata_q <= size_ok ? next_rdata : 32'h0000_0000;
        end
    end

    assign hrdata    = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

endmodule

// ===== rqts_core_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// Tag and sideband checker
// ----------------------------------------
module rqts_core_props (
    // Bus
    input wire logic                     hclk,
    input wire logic                     hresetn,
    input wire logic                     hsel,
    input wire logic [31:0]              haddr,
    input wire logic [1:0]               htrans,
    input wire logic                     hwrite,
    input wire logic [2:0]               hsize,
    input wire logic [31:0]              hwdata,
    input wire logic                     hready,
    // Stream
    input wire logic [127:0]             request_data_bus,
    input wire logic [59:0]              request_sideband_bus,
    input wire logic                     request_last,
    input wire logic                     request_valid,
    input wire logic [3:0]               request_ready,
    // Outputs
    input wire rqts_pkg::rqts_tag_t      nonposted_tag_out,
    input wire logic                     nonposted_tag_valid,
    input wire rqts_pkg::rqts_sideband_t packet_sideband,
    input wire logic                     packet_start
);
    import rqts_pkg::*;
    logic       in_pkt;
    logic       cfg_wr;
    logic       utag;
    logic       accept;
    logic [3:0] pend;
    rqts_tag_t  exp_tag;
    wire        taken = request_valid && request_ready[0];
    wire        first = taken && !in_pkt;
    wire [3:0]  rtype = request_data_bus[78:75];
    wire        posted = rtype == 4'h1 || (rtype >= 4'hc && rtype <= 4'he);
    wire        push = first && !posted && !utag;
    wire        ctrl_ap = hsel && hready && htrans == 2'h2 && hwrite;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_pkt <= 1'b0;
            cfg_wr <= 1'b0;
            utag <= 1'b0;
            accept <= 1'b1;
            pend <= 4'h0;
            exp_tag <= 6'h0;
        end else begin
            in_pkt <= taken ? !request_last : in_pkt;
            cfg_wr <= ctrl_ap && haddr[7:0] == 8'h00 && hsize == 3'h2;
            utag <= cfg_wr ? hwdata[0] : utag;
            accept <= cfg_wr ? hwdata[2] : accept;
            pend <= pend + {3'h0, push} - {3'h0, nonposted_tag_valid};
            exp_tag <= exp_tag + {5'h0, nonposted_tag_valid};
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_np_alone;
        push && pend == 4'h0;
    endsequence
    sequence s_report;
        ##2 nonposted_tag_valid && nonposted_tag_out == exp_tag;
    endsequence
    chk_tag_latency:
        assert property (s_np_alone |-> s_report) else $error("tag late");
    chk_tag_order:
        assert property (nonposted_tag_valid |-> nonposted_tag_out == exp_tag)
            else $error("tag order");
    chk_tag_owed:
        assert property (nonposted_tag_valid |-> pend != 4'h0) else $error("extra tag");
    chk_user_quiet:
        assert property (utag && pend == 4'h0 |=> !nonposted_tag_valid [*4])
            else $error("tag in user mode");
    chk_sb_capture:
        assert property (first |=> packet_start
            && packet_sideband == $past(request_sideband_bus[10:0])) else $error("sideband");
    chk_sb_hold:
        assert property (!first |=> !packet_start && $stable(packet_sideband))
            else $error("sideband moved");
    chk_ready_gate:
        assert property (!accept |-> request_ready == 4'h0) else $error("ready open");
    chk_ready_open:
        assert property (accept && pend < 4'h8 |-> request_ready == 4'hf)
            else $error("ready shut");
endmodule

bind rqts_core rqts_core_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .request_data_bus, .request_sideband_bus, .request_last,
    .request_valid, .request_ready, .nonposted_tag_out, .nonposted_tag_valid,
    .packet_sideband, .packet_start);

// ===== rqts_user_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Request issuer model
// ----------------------------------------
module rqts_user_model (
    // Clock
    input wire logic                hclk,
    // Request stream
    output logic [127:0]            request_data_bus,
    output logic [59:0]             request_sideband_bus,
    output logic                    request_last,
    output logic [3:0]              request_keep,
    output logic                    request_valid,
    input wire logic [3:0]          request_ready,
    // Tag report
    input wire rqts_pkg::rqts_tag_t nonposted_tag_out,
    input wire logic                nonposted_tag_valid
);
    import rqts_pkg::*;
    rqts_tag_t tags[$];
    int        timeouts = 0;
    initial begin
        request_data_bus = 128'h0;
        request_sideband_bus = 60'h0;
        request_last = 1'b0;
        request_keep = 4'hf;
        request_valid = 1'b0;
    end
    always @(posedge hclk) begin
        if (nonposted_tag_valid) tags.push_back(nonposted_tag_out);
    end
    task automatic send(input logic [3:0] typ, input logic [10:0] sb, input int beats);
        logic ok;
        for (int b = 0; b < beats; b++) begin
            request_valid <= 1'b1;
            request_last <= (b == beats - 1);
            request_data_bus <= (b == 0) ? {49'h0, typ, 75'h0} : {4{32'(b)}};
            request_sideband_bus <= (b == 0) ? {49'h0, sb} : ~{49'h0, sb};
            ok = 1'b0;
            for (int n = 0; n < 100 && !ok; n++) begin
                @(negedge hclk);
                ok = request_ready[0];
                @(posedge hclk);
            end
            if (!ok) timeouts++;
        end
    endtask
    task automatic idle();
        request_valid <= 1'b0;
        request_data_bus <= ~request_data_bus;
        request_sideband_bus <= ~request_sideband_bus;
    endtask
endmodule

// ===== rqts_core_bench.sv
`timescale 1ns/1ps
`include "rqts_map.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module rqts_core_bench;
    import rqts_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, request_last, request_valid;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [127:0] request_data_bus;
    logic [59:0] request_sideband_bus;
    logic [3:0] request_keep, request_ready;
    rqts_tag_t nonposted_tag_out;
    logic nonposted_tag_valid;
    int n_fail = 0;
    int checks = 0;
    int np = 0;
    logic [3:0] typ [8] = '{4'h0, 4'h1, 4'h2, 4'hc, 4'h3, 4'hd, 4'h4, 4'he};
    logic [7:0] adr [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};

    always #5 hclk = ~hclk;

    rqts_core DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp(), .request_data_bus,
        .request_sideband_bus, .request_last, .request_keep, .request_valid, .request_ready,
        .nonposted_tag_out, .nonposted_tag_valid, .packet_sideband(), .packet_start());
    rqts_user_model USER (.hclk, .request_data_bus, .request_sideband_bus, .request_last,
        .request_keep, .request_valid, .request_ready, .nonposted_tag_out,
        .nonposted_tag_valid);

    task report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_bus();
        logic ok;
        ok = 1'b0;
        for (int n = 0; n < 50 && !ok; n++) begin
            @(negedge hclk);
            ok = hreadyout;
            rd = hrdata;
            @(posedge hclk);
        end
        if (!ok) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= `RQTS_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= `RQTS_HSIZE_WORD;
        wait_bus();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_bus();
        @(posedge hclk);
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK("register", e, rd)
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            expect_reg(adr[i], (i == 0) ? 32'h4 : 32'h0);
        end
        $display("test reset done");
        for (int i = 0; i < 15; i++) begin
            USER.send(typ[i % 8], {3'h0, 4'(i), 4'(~i)}, i % 3 + 1);
            np += (typ[i % 8] inside {4'h1, [4'hc:4'he]}) ? 0 : 1;
        end
        USER.idle();
        repeat (20) @(posedge hclk);
        `CHK("tag count", np, USER.tags.size())
        for (int k = 0; k < np; k++) begin
            `CHK("tag", 6'(k), USER.tags[k])
        end
        expect_reg(`RQTS_NPCOUNT_OFF, 32'(np));
        expect_reg(`RQTS_SIDEBAND_OFF, 32'h0e1);
        expect_reg(`RQTS_STATUS_OFF, {18'h0, 6'(np - 1), 8'h0});
        $display("test tags done");
        bus(1'b1, `RQTS_CTRL_OFF, 32'h0);
        `CHK("ready", 4'h0, request_ready)
        fork
            USER.send(4'h0, 11'h0ff, 2);
            begin
                repeat (6) @(posedge hclk);
                bus(1'b1, `RQTS_CTRL_OFF, 32'h4);
            end
        join
        USER.idle();
        repeat (10) @(posedge hclk);
        `CHK("late tag", 6'(np), USER.tags[np])
        $display("test stall done");
        USER.send(4'h0, 11'h1ff, 1);
        USER.idle();
        expect_reg(`RQTS_ERR_OFF, 32'h1);
        bus(1'b1, `RQTS_ERR_OFF, 32'h1);
        expect_reg(`RQTS_ERR_OFF, 32'h0);
        bus(1'b1, `RQTS_CTRL_OFF, 32'h6);
        USER.send(4'h0, 11'h3ff, 1);
        USER.idle();
        expect_reg(`RQTS_ERR_OFF, 32'h0);
        USER.send(4'h0, 11'h5ff, 1);
        USER.idle();
        expect_reg(`RQTS_ERR_OFF, 32'h1);
        expect_reg(`RQTS_SIDEBAND_OFF, 32'h5ff);
        $display("test offset done");
        bus(1'b1, `RQTS_CTRL_OFF, 32'h5);
        USER.tags.delete();
        USER.send(4'h0, 11'h0ff, 1);
        USER.send(4'h2, 11'h0ff, 1);
        USER.idle();
        repeat (10) @(posedge hclk);
        `CHK("user tags", 0, USER.tags.size())
        expect_reg(`RQTS_NPCOUNT_OFF, 32'(np + 6));
        `CHK("stalls", 0, USER.timeouts)
        $display("test user tags done");
        report_and_stop();
    end
endmodule
